// *** design/cdsb_pkg.sv ***
// constants for the core debug state and breakpoint register block
// What this block does
// - on debug entry, copy the interrupted core's saved status word into the status copy.
// - status bits 0..4: events on, irqs on, event setup, in handler, kernel mode.
// - status bit 7 flags fast issue, bit 6 flags paused waiting for events or lock.
// - bit 8 read-only issue mode, bit 9 entry issue mode, bit 10 address space id.
// - on debug entry store the saved program counter, full 32 bits, read/write.
// - on debug entry store the saved stack pointer, full 32 bits, read/write.
// - handler loads 8-bit core number; block presents it as first read operand.
// - handler loads 5-bit register index; block presents it as second read operand.
// - 3-bit cause code resets to 0: host, debug call, ibreak, data, resource watch.
// - cause bits 15:8 hold the causing thread, zero for host requests.
// - cause bits 17:16 hold firing unit, zero for host/call, lowest wins.
// - event data word takes watch address or resource id on a watchpoint hit.
// - 8-bit run-control vector holds back every marked core after debug return.
// - eight scratch words shared between handler and external config-side debugger.
// - four instruction breakpoints compare their address with the pc and trap.
// - breakpoint control bits 23:16 are a per-thread enable mask, reset 0.
// - control bit 1 selects equal (0) or not-equal (1) match, reset 0.
// - control bit 0 enables the breakpoint, reset 0.
`default_nettype none

package cdsb_pkg;

  // ------------------------------------------------------------
  // bus geometry: printed offsets are word indices
  // ------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;

  // ------------------------------------------------------------
  // register indices (byte address is four times these)
  // ------------------------------------------------------------
  localparam logic [7:0] IX_ISTAT = 8'h08;
  localparam logic [7:0] IX_IMASK = 8'h09;
  localparam logic [7:0] IX_STATUS = 8'h10;
  localparam logic [7:0] IX_PC = 8'h11;
  localparam logic [7:0] IX_SP = 8'h12;
  localparam logic [7:0] IX_TSEL = 8'h13;
  localparam logic [7:0] IX_RSEL = 8'h14;
  localparam logic [7:0] IX_CAUSE = 8'h15;
  localparam logic [7:0] IX_DATA = 8'h16;
  localparam logic [7:0] IX_RUN = 8'h18;
  localparam logic [7:0] IX_SCR = 8'h20;
  localparam logic [7:0] IX_IBA = 8'h30;
  localparam logic [7:0] IX_IBC = 8'h40;
  localparam int SCR_N = 8;
  localparam int BRK_N = 4;
  localparam int THREADS = 8;

  // ------------------------------------------------------------
  // saved status word fields
  // ------------------------------------------------------------
  localparam int EVENTS_ENABLED_BIT = 0;
  localparam int IRQ_ENABLED_BIT = 1;
  localparam int EVENT_SETUP_BIT = 2;
  localparam int IN_HANDLER_BIT = 3;
  localparam int KERNEL_MODE_BIT = 4;
  localparam int PAUSED_WAITING_BIT = 6;
  localparam int FAST_ISSUE_BIT = 7;
  localparam int ISSUE_MODE_BIT = 8;
  localparam int ENTRY_MODE_BIT = 9;
  localparam int ADDRESS_SPACE_ID_BIT = 10;
  localparam logic [31:0] STATUS_CAPTURE_MASK = 32'h0000_07DF;
  localparam logic [31:0] STATUS_SW_MASK = 32'h0000_06DF;

  // ------------------------------------------------------------
  // cause register layout and codes
  // ------------------------------------------------------------
  localparam int CAUSE_THREAD_LSB = 8;
  localparam int CAUSE_UNIT_LSB = 16;
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_CALL = 3'h2;
  localparam logic [2:0] CAUSE_IBRK = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;

  // ------------------------------------------------------------
  // breakpoint control layout
  // ------------------------------------------------------------
  localparam int IBC_ON_BIT = 0;
  localparam int IBC_SENSE_BIT = 1;
  localparam int IBC_MASK_LSB = 16;

  // ------------------------------------------------------------
  // interrupt status bits, reset value
  // ------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_ENTRY = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_MSG = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : cdsb_pkg

`default_nettype wire

// *** design/cdsb_top.sv ***
// debug state capture, run control, scratch and instruction breakpoint block
`default_nettype none

module cdsb_top
  import cdsb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // interrupted core state, sampled on entry
  input wire logic [31:0] coreStatus,
  input wire logic [31:0] corePc,
  input wire logic [31:0] coreSp,
  // debug event sources from the pipeline
  input wire logic hostDbgReq,
  input wire logic dcallReq,
  input wire logic dwatchHit,
  input wire logic rwatchHit,
  input wire logic [2:0] evtThread,
  input wire logic [1:0] evtUnit,
  input wire logic [31:0] evtData,
  // issued instruction, for breakpoint compare
  input wire logic issueValid,
  input wire logic [2:0] issueThread,
  input wire logic [31:0] issuePc,
  // handler return
  input wire logic dbgReturn,
  // outputs to the pipeline
  output logic dbgTrap,
  output logic inDebug,
  output logic [7:0] runHold,
  output logic [7:0] readThreadSel,
  output logic [4:0] readRegSel,
  output logic [31:0] restoreStatus,
  output logic [31:0] restorePc,
  output logic [31:0] restoreSp,
  // tile configuration view of the scratch words
  input wire logic cfgWrite,
  input wire logic [2:0] cfgIdx,
  input wire logic [31:0] cfgWdata,
  output logic [31:0] cfgRdata
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (BRK_N != 4 || THREADS != 8 || SCR_N != 8)
  begin : g_bad_geometry
    $error("cdsb_top supports four breakpoints, eight threads, eight scratch words");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [7:0] tsel;
    logic [4:0] rsel;
    logic [2:0] cause;
    logic [7:0] cthread;
    logic [1:0] cunit;
    logic [31:0] data;
    logic [7:0] run;
    logic [SCR_N-1:0][31:0] scr;
    logic [BRK_N-1:0][31:0] iba;
    logic [BRK_N-1:0][7:0] ibMask;
    logic [BRK_N-1:0] ibSense;
    logic [BRK_N-1:0] ibOn;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] imask;
    logic inDbg;
    logic trap;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [31:0] cfgRd;
    logic irq;
  } cdsb_state_t;

  cdsb_state_t state_reg;
  cdsb_state_t state_next;

  logic [IDX_W-1:0] idx;
  logic wrAcc;
  logic rdSetup;
  logic [BRK_N-1:0] brkHit;
  logic anyEvt;
  logic [IRQ_W-1:0] irqSet;
  logic [31:0] rdWord;
  logic rdMapped;

  // lowest-numbered set bit; ties go to the smaller unit
  function automatic logic [1:0] lowestHit(input logic [BRK_N-1:0] v);
    lowestHit = 2'h0;
    for (int i = BRK_N - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        lowestHit = 2'(i);
      end
    end
  endfunction

  // true when an index falls in a block of consecutive words
  function automatic logic inBlock(input logic [IDX_W-1:0] ix, input logic [IDX_W-1:0] base, input int n);
    inBlock = (ix >= base) && (int'(ix) < int'(base) + n);
  endfunction

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    state_next.trap = 1'b0;
    idx = paddr[IDX_LSB +: IDX_W];
    // writes commit only in the cycle pready is shown; read data is latched in the cycle before
    wrAcc = psel && penable && state_reg.ready && pwrite;
    rdSetup = psel && penable && !state_reg.ready;
    irqSet = '0;

    // breakpoint compare per issued instruction
    brkHit = '0;
    for (int b = 0; b < BRK_N; b++)
    begin
      brkHit[b] = issueValid && state_reg.ibOn[b]
        && state_reg.ibMask[b][issueThread]
        && (state_reg.ibSense[b] ? (issuePc != state_reg.iba[b])
                                 : (issuePc == state_reg.iba[b]));
    end
    anyEvt = hostDbgReq || dcallReq || (|brkHit) || dwatchHit || rwatchHit;

    // software writes
    if (wrAcc)
    begin
      if (idx == IX_STATUS)
      begin
        // issue-mode bit 8 and reserved bits keep their value
        state_next.status = (state_reg.status & ~STATUS_SW_MASK) | (pwdata & STATUS_SW_MASK);
      end
      if (idx == IX_PC)
      begin
        state_next.pc = pwdata;
      end
      if (idx == IX_SP)
      begin
        state_next.sp = pwdata;
      end
      if (idx == IX_TSEL)
      begin
        state_next.tsel = pwdata[7:0];
      end
      if (idx == IX_RSEL)
      begin
        state_next.rsel = pwdata[4:0];
      end
      if (idx == IX_CAUSE)
      begin
        state_next.cause = pwdata[2:0];
        state_next.cthread = pwdata[CAUSE_THREAD_LSB +: 8];
        state_next.cunit = pwdata[CAUSE_UNIT_LSB +: 2];
      end
      if (idx == IX_DATA)
      begin
        state_next.data = pwdata;
      end
      if (idx == IX_RUN)
      begin
        state_next.run = pwdata[7:0];
      end
      if (inBlock(idx, IX_SCR, SCR_N))
      begin
        state_next.scr[idx[2:0]] = pwdata;
      end
      if (inBlock(idx, IX_IBA, BRK_N))
      begin
        state_next.iba[idx[1:0]] = pwdata;
      end
      if (inBlock(idx, IX_IBC, BRK_N))
      begin
        state_next.ibMask[idx[1:0]] = pwdata[IBC_MASK_LSB +: 8];
        state_next.ibSense[idx[1:0]] = pwdata[IBC_SENSE_BIT];
        state_next.ibOn[idx[1:0]] = pwdata[IBC_ON_BIT];
      end
      if (idx == IX_IMASK)
      begin
        state_next.imask = pwdata[IRQ_W-1:0];
      end
      if (idx == IX_ISTAT)
      begin
        // write one to clear
        state_next.istat = state_reg.istat & ~pwdata[IRQ_W-1:0];
      end
    end

    // the configuration side wins a same-cycle clash on a scratch word
    if (cfgWrite)
    begin
      state_next.scr[cfgIdx] = cfgWdata;
      irqSet[IRQ_MSG] = 1'b1;
    end

    // handler return releases the debug state
    if (dbgReturn)
    begin
      state_next.inDbg = 1'b0;
    end

    // debug entry: capture beats a software write in the same cycle
    if (anyEvt && !state_reg.inDbg)
    begin
      state_next.inDbg = 1'b1;
      state_next.trap = 1'b1;
      state_next.status = coreStatus & STATUS_CAPTURE_MASK;
      state_next.pc = corePc;
      state_next.sp = coreSp;
      irqSet[IRQ_ENTRY] = 1'b1;
      // fixed priority: host, call, ibreak, data watch, resource watch
      if (hostDbgReq)
      begin
        state_next.cause = CAUSE_HOST;
        state_next.cthread = 8'h00;
        state_next.cunit = 2'h0;
      end
      else if (dcallReq)
      begin
        state_next.cause = CAUSE_CALL;
        state_next.cthread = {5'h00, evtThread};
        state_next.cunit = 2'h0;
      end
      else if (|brkHit)
      begin
        state_next.cause = CAUSE_IBRK;
        state_next.cthread = {5'h00, issueThread};
        state_next.cunit = lowestHit(brkHit);
      end
      else if (dwatchHit)
      begin
        state_next.cause = CAUSE_DWATCH;
        state_next.cthread = {5'h00, evtThread};
        state_next.cunit = evtUnit;
        state_next.data = evtData;
      end
      else
      begin
        state_next.cause = CAUSE_RWATCH;
        state_next.cthread = {5'h00, evtThread};
        state_next.cunit = evtUnit;
        state_next.data = evtData;
      end
    end
    else if (anyEvt)
    begin
      // already in the handler: the event is dropped but flagged
      irqSet[IRQ_LOST] = 1'b1;
    end

    // sticky status: a set in the clearing cycle survives
    state_next.istat = state_next.istat | irqSet;
    state_next.irq = |(state_next.istat & state_next.imask);

    // register read decode; unmapped indices answer with an error
    rdWord = RST_WORD;
    rdMapped = 1'b1;
    if (idx == IX_STATUS)
    begin
      rdWord = state_reg.status;
    end
    else if (idx == IX_PC)
    begin
      rdWord = state_reg.pc;
    end
    else if (idx == IX_SP)
    begin
      rdWord = state_reg.sp;
    end
    else if (idx == IX_TSEL)
    begin
      rdWord = {24'h000000, state_reg.tsel};
    end
    else if (idx == IX_RSEL)
    begin
      rdWord = {27'h0000000, state_reg.rsel};
    end
    else if (idx == IX_CAUSE)
    begin
      rdWord = {14'h0000, state_reg.cunit, state_reg.cthread, 5'h00, state_reg.cause};
    end
    else if (idx == IX_DATA)
    begin
      rdWord = state_reg.data;
    end
    else if (idx == IX_RUN)
    begin
      rdWord = {24'h000000, state_reg.run};
    end
    else if (inBlock(idx, IX_SCR, SCR_N))
    begin
      rdWord = state_reg.scr[idx[2:0]];
    end
    else if (inBlock(idx, IX_IBA, BRK_N))
    begin
      rdWord = state_reg.iba[idx[1:0]];
    end
    else if (inBlock(idx, IX_IBC, BRK_N))
    begin
      rdWord = {8'h00, state_reg.ibMask[idx[1:0]], 14'h0000,
                state_reg.ibSense[idx[1:0]], state_reg.ibOn[idx[1:0]]};
    end
    else if (idx == IX_ISTAT)
    begin
      rdWord = {29'h00000000, state_reg.istat};
    end
    else if (idx == IX_IMASK)
    begin
      rdWord = {29'h00000000, state_reg.imask};
    end
    else
    begin
      rdMapped = 1'b0;
    end

    // one wait state: pready rises in the second access cycle
    state_next.ready = rdSetup;
    state_next.slverr = rdSetup && !rdMapped;
    if (rdSetup && !pwrite)
    begin
      state_next.rdata = rdWord;
    end
    state_next.cfgRd = state_reg.scr[cfgIdx];
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.slverr;
  assign irq = state_reg.irq;
  assign dbgTrap = state_reg.trap;
  assign inDebug = state_reg.inDbg;
  assign runHold = state_reg.run;
  assign readThreadSel = state_reg.tsel;
  assign readRegSel = state_reg.rsel;
  assign restoreStatus = state_reg.status;
  assign restorePc = state_reg.pc;
  assign restoreSp = state_reg.sp;
  assign cfgRdata = state_reg.cfgRd;

endmodule // cdsb_top

`default_nettype wire

// *** verif/cdsb_pipe_model.sv ***
// pipeline issue model feeding the breakpoint compare
`default_nettype none

module cdsb_pipe_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // issue request from the bench
  input wire logic go,
  input wire logic [2:0] thr,
  input wire logic [31:0] bpc,
  input wire logic [7:0] runHold,
  // issued instruction
  output logic issueValid,
  output logic [2:0] issueThread,
  output logic [31:0] issuePc
);
  timeunit 1ns;
  timeprecision 1ns;
  // held cores never issue; idle values are inverted so stale ones never match
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      issueValid <= 1'b0;
      issueThread <= 3'h0;
      issuePc <= 32'h0;
    end
    else
    begin
      issueValid <= go && !runHold[thr];
      issueThread <= go ? thr : ~issueThread;
      issuePc <= go ? bpc : ~issuePc;
    end
  end
endmodule // cdsb_pipe_model

`default_nettype wire

// *** verif/cdsb_properties.sv ***
// assertion checker for the debug state block, bound to its top
`default_nettype none

module cdsb_checker
  import cdsb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // debug events and core state
  input wire logic hostDbgReq,
  input wire logic dcallReq,
  input wire logic dwatchHit,
  input wire logic rwatchHit,
  input wire logic [31:0] coreStatus,
  input wire logic [31:0] corePc,
  input wire logic [31:0] coreSp,
  input wire logic dbgReturn,
  // debug outputs
  input wire logic dbgTrap,
  input wire logic inDebug,
  input wire logic [31:0] restoreStatus,
  input wire logic [31:0] restorePc,
  input wire logic [31:0] restoreSp,
  // config view of scratch
  input wire logic cfgWrite,
  input wire logic [2:0] cfgIdx,
  input wire logic [31:0] cfgWdata,
  input wire logic [31:0] cfgRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic evIn;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // breakpoint hits are not visible here, so only the wired sources count
  assign evIn = !inDebug && (hostDbgReq || dcallReq || dwatchHit || rwatchHit);

  AST_ENTRY: assert property (evIn |=> dbgTrap && inDebug)
    else $error("debug entry missed");
  AST_STATUS_CAPTURE: assert property (evIn |=> restoreStatus == ($past(coreStatus) & STATUS_CAPTURE_MASK))
    else $error("status copy wrong");
  AST_PC_CAPTURE: assert property (evIn |=> restorePc == $past(corePc))
    else $error("pc copy wrong");
  AST_SP_CAPTURE: assert property (evIn |=> restoreSp == $past(coreSp))
    else $error("sp copy wrong");
  AST_RESERVED_ZERO: assert property (restoreStatus[31:11] == 21'h0 && !restoreStatus[5])
    else $error("reserved status bit set");
  AST_TRAP_ONCE: assert property (inDebug |=> !dbgTrap)
    else $error("trap while already in debug");
  AST_RETURN: assert property (dbgReturn && inDebug |=> !inDebug)
    else $error("return did not leave debug");
  AST_APB_READY: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  AST_CFG_VIEW: assert property (cfgWrite ##1 ($stable(cfgIdx) && !cfgWrite) |=> cfgRdata == $past(cfgWdata, 2))
    else $error("config view stale");
endmodule // cdsb_checker

bind cdsb_top cdsb_checker u_cdsb_checker (.sys_clk, .rst_n, .psel, .penable, .pready, .hostDbgReq, .dcallReq,
  .dwatchHit, .rwatchHit, .coreStatus, .corePc, .coreSp, .dbgReturn, .dbgTrap, .inDebug, .restoreStatus,
  .restorePc, .restoreSp, .cfgWrite, .cfgIdx, .cfgWdata, .cfgRdata);

`default_nettype wire

// *** verif/cdsb_top_tb.sv ***
// self-checking bench for the debug state block
`default_nettype none

module cdsb_top_tb
  import cdsb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic hostDbgReq = 1'b0, dcallReq = 1'b0, dwatchHit = 1'b0, rwatchHit = 1'b0, dbgReturn = 1'b0;
  logic cfgWrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, coreStatus = 32'h0, corePc = 32'h0, coreSp = 32'h0, evtData = 32'h0;
  logic [31:0] bpc = 32'h0, cfgWdata = 32'h0, seed = 32'h37D2, rd, got, prdata, issuePc, cfgRdata;
  logic [2:0] evtThread = 3'h0, thr = 3'h0, cfgIdx = 3'h0, issueThread;
  logic [1:0] evtUnit = 2'h0;
  logic [7:0] runHold, readThreadSel;
  logic [4:0] readRegSel;
  logic er, pready, pslverr, irq, issueValid, dbgTrap, inDebug;
  logic [31:0] scr [8];
  logic [7:0] rwIx [6] = '{IX_TSEL, IX_RSEL, IX_RUN, IX_PC, IX_SP, IX_DATA};
  logic [31:0] rwMk [6] = '{32'hFF, 32'h1F, 32'hFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  int failures = 0;
  int num_checks = 0;

  cdsb_top u_cdsb_top (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .coreStatus, .corePc, .coreSp, .hostDbgReq, .dcallReq, .dwatchHit, .rwatchHit, .evtThread, .evtUnit,
    .evtData, .issueValid, .issueThread, .issuePc, .dbgReturn, .dbgTrap, .inDebug, .runHold, .readThreadSel,
    .readRegSel, .restoreStatus(), .restorePc(), .restoreSp(), .cfgWrite, .cfgIdx, .cfgWdata, .cfgRdata);
  cdsb_pipe_model u_cdsb_pipe_model (.sys_clk, .rst_n, .go, .thr, .bpc, .runHold, .issueValid, .issueThread,
    .issuePc);

  // ----
  // helpers
  // ----
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // host clears thread, host and call clear unit
  function automatic logic [31:0] causeExp(logic [2:0] k, logic [2:0] t, logic [1:0] u);
    logic [7:0] th;
    logic [1:0] un;
    th = (k == CAUSE_HOST) ? 8'h0 : {5'h0, t};
    un = (k == CAUSE_HOST || k == CAUSE_CALL) ? 2'h0 : u;
    return {14'h0, un, th, 5'h0, k};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer, then an idle edge so back-to-back calls never clash
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] ix, input logic [31:0] exp);
    apb(1'b0, ix, 32'h0);
    chk(nm, rd, exp);
  endtask

  // raise one debug event, check what was captured, then return
  task automatic ev(input logic [2:0] k, input logic [2:0] t, input logic [1:0] u, input logic [31:0] pc);
    logic [31:0] st, cp, d;
    int n;
    st = xs();
    cp = xs();
    d = xs();
    n = 0;
    coreStatus <= st;
    corePc <= cp;
    coreSp <= ~cp;
    evtThread <= t;
    evtUnit <= (k == CAUSE_IBRK) ? ~u : u;
    evtData <= d;
    thr <= t;
    bpc <= pc;
    {hostDbgReq, dcallReq, go, dwatchHit, rwatchHit} <= 5'b10000 >> (k - 3'h1);
    @(posedge sys_clk);
    {hostDbgReq, dcallReq, go, dwatchHit, rwatchHit} <= 5'h0;
    while (dbgTrap !== 1'b1 && n < 8)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 8)
    begin
      failures++;
      results();
    end
    chk("trap", {31'h0, dbgTrap}, 32'h1);
    rdc("cause", IX_CAUSE, causeExp(k, t, u));
    rdc("status", IX_STATUS, st & STATUS_CAPTURE_MASK);
    rdc("pc", IX_PC, cp);
    rdc("sp", IX_SP, ~cp);
    if (k >= CAUSE_DWATCH)
      rdc("data", IX_DATA, d);
    dbgReturn <= 1'b1;
    @(posedge sys_clk);
    dbgReturn <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc("cause0", IX_CAUSE, RST_WORD);
    for (int k = 0; k < BRK_N; k++)
      rdc("ibc0", IX_IBC + 8'(k), RST_WORD);
    apb(1'b1, IX_STATUS, 32'hFFFFFFFF);
    rdc("swmask", IX_STATUS, STATUS_SW_MASK);
    $display("reset test done");
    for (int j = 0; j < 6; j++)
    begin
      got = xs();
      apb(1'b1, rwIx[j], got);
      rdc("rw", rwIx[j], got & rwMk[j]);
      if (j == 0)
        chk("tsel", {24'h0, readThreadSel}, {24'h0, got[7:0]});
    end
    got = seed;
    apb(1'b1, IX_TSEL, got);
    apb(1'b1, IX_RSEL, got);
    apb(1'b1, IX_RUN, got);
    chk("tselport", {24'h0, readThreadSel}, {24'h0, got[7:0]});
    chk("rselport", {27'h0, readRegSel}, {27'h0, got[4:0]});
    chk("holdport", {24'h0, runHold}, {24'h0, got[7:0]});
    apb(1'b1, IX_RUN, 32'h0);
    apb(1'b0, 8'h17, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
    chk("unmappedrd", rd, 32'h0);
    $display("register test done");
    for (int k = 0; k < SCR_N; k++)
    begin
      scr[k] = xs();
      apb(1'b1, IX_SCR + 8'(k), scr[k]);
    end
    for (int k = 0; k < SCR_N; k++)
    begin
      cfgIdx <= 3'(k);
      repeat (2) @(posedge sys_clk);
      chk("cfgview", cfgRdata, scr[k]);
    end
    cfgWrite <= 1'b1;
    cfgIdx <= 3'h5;
    cfgWdata <= xs();
    @(posedge sys_clk);
    cfgWrite <= 1'b0;
    rdc("scrview", IX_SCR + 8'h5, cfgWdata);
    $display("scratch test done");
    apb(1'b1, IX_IMASK, 32'h1);
    apb(1'b1, IX_ISTAT, 32'h7);
    for (int k = 1; k <= 5; k++)
      if (k != 3)
        ev(3'(k), 3'(k + 2), 2'(k), 32'h0);
    got = xs();
    apb(1'b1, IX_IBA, got);
    apb(1'b1, IX_IBC, 32'h0004_0000);
    apb(1'b1, IX_IBA + 8'h1, got);
    apb(1'b1, IX_IBC + 8'h1, 32'h0004_0001);
    apb(1'b1, IX_IBA + 8'h2, got);
    apb(1'b1, IX_IBC + 8'h2, 32'h0008_0001);
    apb(1'b1, IX_IBA + 8'h3, ~got);
    apb(1'b1, IX_IBC + 8'h3, 32'h0004_0003);
    ev(CAUSE_IBRK, 3'h2, 2'h1, got);
    ev(CAUSE_IBRK, 3'h3, 2'h2, got);
    thr <= 3'h3;
    bpc <= ~got;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("nohit", {31'h0, inDebug}, 32'h0);
    $display("breakpoint test done");
    chk("irqset", {31'h0, irq}, 32'h1);
    rdc("istat", IX_ISTAT, 32'h1);
    apb(1'b1, IX_ISTAT, 32'h1);
    @(posedge sys_clk);
    chk("irqclr", {31'h0, irq}, 32'h0);
    apb(1'b1, IX_IMASK, 32'h0);
    ev(CAUSE_CALL, 3'h6, 2'h0, 32'h0);
    chk("irqmask", {31'h0, irq}, 32'h0);
    $display("interrupt test done");
    results();
  end
endmodule // cdsb_top_tb

`default_nettype wire
